/* core/cdsop_pkg.sv */
// shared constants for the compute-engine serial output block
package cdsop_pkg;
    // register byte addresses
    localparam logic [15:0] ADDR_TEST_SEL = 16'h2000;
    localparam logic [15:0] ADDR_MON_CTL = 16'h2001;
    localparam logic [15:0] ADDR_SER_CTL = 16'h2002;
    localparam logic [15:0] ADDR_MON_A0 = 16'h2003;
    localparam logic [15:0] ADDR_SER_START = 16'h2007;
    localparam logic [15:0] ADDR_SER_END = 16'h2008;
    localparam logic [15:0] ADDR_STATUS = 16'h2009;
    // serial control field positions
    localparam int SER_EN_BIT = 0;
    localparam int SER_RATE_BIT = 1;
    localparam int SER_GATE_BIT = 2;
    localparam int SER_RDYEN_BIT = 3;
    localparam int SER_FSIZE_LSB = 4;
    localparam int SER_POL_BIT = 6;
    localparam int SER_CTL_W = 7;
    // values after reset
    localparam logic [3:0] TEST_SEL_RST = 4'h0;
    localparam logic [6:0] SER_CTL_RST = 7'h00;
    // test select codes
    localparam logic [3:0] TSEL_RTM = 4'h4;
    localparam logic [3:0] TSEL_CMP2 = 4'h6;
    localparam logic [3:0] TSEL_CMP3 = 4'h7;
    localparam logic [3:0] TSEL_RXD = 4'h8;
    localparam logic [3:0] TSEL_SYNC = 4'h9;
    localparam logic [3:0] TSEL_CK10 = 4'ha;
    localparam logic [3:0] TSEL_CKCPU = 4'hb;
    localparam logic [3:0] TSEL_CLOCK_38KHZ = 4'hd;
    localparam logic [3:0] TSEL_ANA_LAST = 4'h3;
    // cycle counts
    localparam logic [1:0] MON_DIV = 2'h3;
    localparam logic [5:0] MON_LAST_BIT = 6'h22;
    localparam logic [5:0] MON_DATA_TOP = 6'h20;
    localparam logic [1:0] MON_LAST_WORD = 2'h3;
    localparam logic [1:0] SER_HALF_SLOW = 2'h1;
    localparam logic [1:0] SER_HALF_FAST = 2'h0;
    localparam logic [2:0] SER_LEAD_SLOW = 3'h1;
    localparam logic [2:0] SER_LEAD_FAST = 3'h2;
    localparam logic [2:0] SER_TAIL_LAST = 3'h2;
    // monitor and serial states
    typedef enum logic [1:0] {M_IDLE, M_LOAD, M_SHIFT} cdsop_mon_state_type;
    typedef enum logic [2:0] {S_IDLE, S_LEAD, S_FIELD, S_DATA, S_TAIL} cdsop_ser_state_type;
endpackage

/* core/cdsop_core.sv */
// monitor stream, synchronous serial port and test output multiplexer
`timescale 1ns/100ps

module cdsop_core #(
    parameter int AW = 9
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // register port
    input wire logic [15:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // compute engine side
    input wire logic mux_sync_in,
    output logic [AW-1:0] mon_ram_addr_out,
    input wire logic [31:0] mon_ram_data_in,
    output logic [AW-1:0] ser_ram_addr_out,
    input wire logic [31:0] ser_ram_data_in,
    // test multiplexer sources and output
    input wire logic comparator2_in,
    input wire logic comparator3_in,
    input wire logic optical_rxd_in,
    input wire logic clock_10mhz_in,
    input wire logic processor_clock_in,
    input wire logic clock_38khz_in,
    output logic test_output_pin_out,
    output logic analog_test_en_out,
    output logic [1:0] analog_test_sel_out,
    // shared segment pins
    input wire logic [3:0] lcd_seg_in,
    output logic seg3_pin_out,
    output logic seg4_pin_out,
    output logic seg5_pin_out,
    input wire logic seg6_pin_in,
    output logic seg6_pin_out,
    output logic seg6_pin_oe_out,
    output logic lcd_disable_out
);

    ////////////////////////////////////////////////////////////////////////
    // register file
    logic [3:0] tsel_reg, tsel_next; // test output select
    logic mon_en_reg, mon_en_next; // monitor enable
    logic [6:0] sctl_reg, sctl_next; // serial control
    logic [AW-1:0] maddr_reg [4]; // monitor word addresses
    logic [AW-1:0] maddr_next [4];
    logic [AW-1:0] sstart_reg, sstart_next; // block start
    logic [AW-1:0] send_reg, send_next; // block end
    logic [15:0] rdata_reg, rdata_next; // read data, one cycle late
    logic mon_busy, ser_busy;

    // field size code to field length; zero means whole block
    function automatic logic [5:0] field_bits(input logic [1:0] code);
        case (code)
            2'h1: field_bits = 6'h08;
            2'h2: field_bits = 6'h10;
            2'h3: field_bits = 6'h20;
            default: field_bits = 6'h00;
        endcase
    endfunction

    // control bits unpacked
    logic ser_en, ser_fast, ser_gate, ser_rdyen, ser_pol;
    logic [1:0] ser_fsize;
    assign ser_en = sctl_reg[cdsop_pkg::SER_EN_BIT];
    assign ser_fast = sctl_reg[cdsop_pkg::SER_RATE_BIT];
    assign ser_gate = sctl_reg[cdsop_pkg::SER_GATE_BIT];
    assign ser_rdyen = sctl_reg[cdsop_pkg::SER_RDYEN_BIT];
    assign ser_fsize = sctl_reg[cdsop_pkg::SER_FSIZE_LSB +: 2];
    assign ser_pol = sctl_reg[cdsop_pkg::SER_POL_BIT];

    // register writes and read mux
    always_comb begin
        tsel_next = tsel_reg;
        mon_en_next = mon_en_reg;
        sctl_next = sctl_reg;
        maddr_next = maddr_reg;
        sstart_next = sstart_reg;
        send_next = send_reg;
        rdata_next = 16'h0000;
        if (reg_wr_in) begin
            case (reg_addr_in)
                cdsop_pkg::ADDR_TEST_SEL: tsel_next = reg_wdata_in[3:0];
                cdsop_pkg::ADDR_MON_CTL: mon_en_next = reg_wdata_in[0];
                cdsop_pkg::ADDR_SER_CTL: sctl_next = reg_wdata_in[6:0];
                cdsop_pkg::ADDR_SER_START: sstart_next = reg_wdata_in[AW-1:0];
                cdsop_pkg::ADDR_SER_END: send_next = reg_wdata_in[AW-1:0];
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (reg_addr_in == cdsop_pkg::ADDR_MON_A0 + 16'(i)) begin
                            maddr_next[i] = reg_wdata_in[AW-1:0];
                        end
                    end
                end
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                cdsop_pkg::ADDR_TEST_SEL: rdata_next = {12'h000, tsel_reg};
                cdsop_pkg::ADDR_MON_CTL: rdata_next = {15'h0000, mon_en_reg};
                cdsop_pkg::ADDR_SER_CTL: rdata_next = {9'h000, sctl_reg};
                cdsop_pkg::ADDR_SER_START: rdata_next = 16'(sstart_reg);
                cdsop_pkg::ADDR_SER_END: rdata_next = 16'(send_reg);
                cdsop_pkg::ADDR_STATUS: rdata_next = {14'h0000, ser_busy, mon_busy};
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (reg_addr_in == cdsop_pkg::ADDR_MON_A0 + 16'(i)) begin
                            rdata_next = 16'(maddr_reg[i]);
                        end
                    end
                end
            endcase
        end
    end

    // register storage
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tsel_reg <= cdsop_pkg::TEST_SEL_RST;
            mon_en_reg <= 1'b0;
            sctl_reg <= cdsop_pkg::SER_CTL_RST;
            maddr_reg <= '{default: '0};
            sstart_reg <= '0;
            send_reg <= '0;
            rdata_reg <= 16'h0000;
        end else begin
            tsel_reg <= tsel_next;
            mon_en_reg <= mon_en_next;
            sctl_reg <= sctl_next;
            maddr_reg <= maddr_next;
            sstart_reg <= sstart_next;
            send_reg <= send_next;
            rdata_reg <= rdata_next;
        end
    end
    assign reg_rdata_out = rdata_reg;

    ////////////////////////////////////////////////////////////////////////
    // sync edge and monitor shift divider
    logic sync_d_reg; // last sync level
    logic sync_rise;
    logic [1:0] mdiv_reg, mdiv_next; // free running divide by four
    logic mon_tick;
    assign sync_rise = mux_sync_in & ~sync_d_reg;
    assign mon_tick = (mdiv_reg == cdsop_pkg::MON_DIV);
    assign mdiv_next = mdiv_reg + 2'h1;

    // monitor state
    cdsop_pkg::cdsop_mon_state_type mon_st_reg, mon_st_next;
    logic [1:0] midx_reg, midx_next; // word in progress
    logic [5:0] mcnt_reg, mcnt_next; // tick within word
    logic mbit_reg, mbit_next; // monitor stream bit
    logic [AW-1:0] maddr_out_reg, maddr_out_next;
    logic [4:0] mon_bidx;
    // data bit for tick 1..32, msb first after the flag
    assign mon_bidx = 5'(cdsop_pkg::MON_DATA_TOP - mcnt_reg);
    assign mon_busy = (mon_st_reg != cdsop_pkg::M_IDLE);

    // monitor sequencer: the ram address is held for a whole word so
    // the read data are long settled when each bit is taken
    always_comb begin
        mon_st_next = mon_st_reg;
        midx_next = midx_reg;
        mcnt_next = mcnt_reg;
        mbit_next = 1'b0;
        maddr_out_next = maddr_out_reg;
        case (mon_st_reg)
            cdsop_pkg::M_IDLE: begin
                if (mon_en_reg && sync_rise) begin
                    midx_next = 2'h0;
                    maddr_out_next = maddr_reg[0];
                    mon_st_next = cdsop_pkg::M_LOAD;
                end
            end
            cdsop_pkg::M_LOAD: begin
                // wait one tick so the first word has arrived
                if (mon_tick) begin
                    mcnt_next = 6'h00;
                    mon_st_next = cdsop_pkg::M_SHIFT;
                end
            end
            cdsop_pkg::M_SHIFT: begin
                mbit_next = mbit_reg;
                if (mon_tick) begin
                    if (mcnt_reg == 6'h00) begin
                        mbit_next = 1'b1;
                    end else if (mcnt_reg <= cdsop_pkg::MON_DATA_TOP) begin
                        mbit_next = mon_ram_data_in[mon_bidx];
                    end else begin
                        mbit_next = 1'b0;
                    end
                    mcnt_next = mcnt_reg + 6'h01;
                    if (mcnt_reg == cdsop_pkg::MON_LAST_BIT) begin
                        mcnt_next = 6'h00;
                        if (midx_reg == cdsop_pkg::MON_LAST_WORD) begin
                            mon_st_next = cdsop_pkg::M_IDLE;
                        end else begin
                            midx_next = midx_reg + 2'h1;
                            maddr_out_next = maddr_reg[midx_reg + 2'h1];
                        end
                    end
                end
            end
            default: mon_st_next = cdsop_pkg::M_IDLE;
        endcase
        if (!mon_en_reg) begin
            mon_st_next = cdsop_pkg::M_IDLE;
            mbit_next = 1'b0;
        end
    end

    // monitor registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            sync_d_reg <= 1'b0;
            mdiv_reg <= 2'h0;
            mon_st_reg <= cdsop_pkg::M_IDLE;
            midx_reg <= 2'h0;
            mcnt_reg <= 6'h00;
            mbit_reg <= 1'b0;
            maddr_out_reg <= '0;
        end else begin
            sync_d_reg <= mux_sync_in;
            mdiv_reg <= mdiv_next;
            mon_st_reg <= mon_st_next;
            midx_reg <= midx_next;
            mcnt_reg <= mcnt_next;
            mbit_reg <= mbit_next;
            maddr_out_reg <= maddr_out_next;
        end
    end
    assign mon_ram_addr_out = maddr_out_reg;

    ////////////////////////////////////////////////////////////////////////
    // serial clock generation
    cdsop_pkg::cdsop_ser_state_type ser_st_reg, ser_st_next;
    logic [1:0] hcnt_reg, hcnt_next; // half period counter
    logic sclk_reg, sclk_next;
    logic clk_run, toggle, rise;
    logic [1:0] half_last;
    assign half_last = ser_fast ? cdsop_pkg::SER_HALF_FAST : cdsop_pkg::SER_HALF_SLOW;
    // gated mode runs only while a transfer is in progress
    assign clk_run = ser_en && (!ser_gate || ser_st_reg != cdsop_pkg::S_IDLE);
    assign toggle = clk_run && (hcnt_reg == half_last);
    assign rise = toggle && !sclk_reg;

    // clock divider next values
    always_comb begin
        sclk_next = sclk_reg;
        hcnt_next = hcnt_reg + 2'h1;
        if (!clk_run) begin
            sclk_next = 1'b0;
            hcnt_next = 2'h0;
        end else if (toggle) begin
            sclk_next = ~sclk_reg;
            hcnt_next = 2'h0;
        end
    end

    // serial framer state
    logic [2:0] lcnt_reg, lcnt_next; // lead and tail clocks
    logic [4:0] bidx_reg, bidx_next; // bit of current word
    logic [5:0] fcnt_reg, fcnt_next; // bits sent in field
    logic frame_reg, frame_next; // frame pulse, true level
    logic sbit_reg, sbit_next; // serial data bit
    logic [AW-1:0] saddr_reg, saddr_next; // current word address
    logic rdy_ok;
    logic [5:0] flen;
    logic [2:0] lead_last;
    assign rdy_ok = !ser_rdyen || seg6_pin_in;
    assign flen = field_bits(ser_fsize);
    assign lead_last = ser_fast ? cdsop_pkg::SER_LEAD_FAST : cdsop_pkg::SER_LEAD_SLOW;
    assign ser_busy = (ser_st_reg != cdsop_pkg::S_IDLE);

    // framer: a transfer starts on a sync rise, then every change is made on a rising serial clock; the next
    // word address is set right after the last bit, and at least two
    // system cycles pass before its first bit is taken
    always_comb begin
        ser_st_next = ser_st_reg;
        lcnt_next = lcnt_reg;
        bidx_next = bidx_reg;
        fcnt_next = fcnt_reg;
        frame_next = frame_reg;
        sbit_next = sbit_reg;
        saddr_next = saddr_reg;
        case (ser_st_reg)
            cdsop_pkg::S_IDLE: begin
                if (ser_en && sync_rise) begin
                    lcnt_next = 3'h0;
                    bidx_next = 5'h1f;
                    saddr_next = sstart_reg;
                    ser_st_next = cdsop_pkg::S_LEAD;
                end
            end
            cdsop_pkg::S_LEAD: begin
                if (rise) begin
                    lcnt_next = lcnt_reg + 3'h1;
                    if (lcnt_reg == lead_last) begin
                        ser_st_next = cdsop_pkg::S_FIELD;
                    end
                end
            end
            cdsop_pkg::S_FIELD: begin
                if (rise && rdy_ok) begin
                    frame_next = 1'b1;
                    fcnt_next = 6'h00;
                    ser_st_next = cdsop_pkg::S_DATA;
                end
            end
            cdsop_pkg::S_DATA: begin
                if (rise) begin
                    frame_next = 1'b0;
                    sbit_next = ser_ram_data_in[bidx_reg];
                    bidx_next = bidx_reg - 5'h01;
                    fcnt_next = fcnt_reg + 6'h01;
                    if (bidx_reg == 5'h00 && saddr_reg == send_reg) begin
                        lcnt_next = 3'h0;
                        ser_st_next = cdsop_pkg::S_TAIL;
                    end else begin
                        if (bidx_reg == 5'h00) begin
                            saddr_next = saddr_reg + 1'b1;
                        end
                        if (flen != 6'h00 && fcnt_reg + 6'h01 == flen) begin
                            ser_st_next = cdsop_pkg::S_FIELD;
                        end
                    end
                end
            end
            cdsop_pkg::S_TAIL: begin
                if (rise) begin
                    lcnt_next = lcnt_reg + 3'h1;
                    if (lcnt_reg == cdsop_pkg::SER_TAIL_LAST) begin
                        ser_st_next = cdsop_pkg::S_IDLE;
                    end
                end
            end
            default: ser_st_next = cdsop_pkg::S_IDLE;
        endcase
        if (!ser_en) begin
            ser_st_next = cdsop_pkg::S_IDLE;
            frame_next = 1'b0;
            sbit_next = 1'b0;
        end
    end

    // serial registers
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ser_st_reg <= cdsop_pkg::S_IDLE;
            hcnt_reg <= 2'h0;
            sclk_reg <= 1'b0;
            lcnt_reg <= 3'h0;
            bidx_reg <= 5'h1f;
            fcnt_reg <= 6'h00;
            frame_reg <= 1'b0;
            sbit_reg <= 1'b0;
            saddr_reg <= '0;
        end else begin
            ser_st_reg <= ser_st_next;
            hcnt_reg <= hcnt_next;
            sclk_reg <= sclk_next;
            lcnt_reg <= lcnt_next;
            bidx_reg <= bidx_next;
            fcnt_reg <= fcnt_next;
            frame_reg <= frame_next;
            sbit_reg <= sbit_next;
            saddr_reg <= saddr_next;
        end
    end
    assign ser_ram_addr_out = saddr_reg;

    // pin sharing: the lcd keeps the pins while the port is off
    assign seg3_pin_out = ser_en ? sclk_reg : lcd_seg_in[0];
    assign seg4_pin_out = ser_en ? sbit_reg : lcd_seg_in[1];
    assign seg5_pin_out = ser_en ? (frame_reg ^ ser_pol) : lcd_seg_in[2];
    assign seg6_pin_out = lcd_seg_in[3];
    assign seg6_pin_oe_out = !ser_en;
    assign lcd_disable_out = ser_en;

    ////////////////////////////////////////////////////////////////////////
    // test output multiplexer; analog codes drive a selector, pin low
    logic tpin_reg, tpin_next;
    always_comb begin
        case (tsel_reg)
            cdsop_pkg::TSEL_RTM: tpin_next = mbit_reg;
            cdsop_pkg::TSEL_CMP2: tpin_next = comparator2_in;
            cdsop_pkg::TSEL_CMP3: tpin_next = comparator3_in;
            cdsop_pkg::TSEL_RXD: tpin_next = optical_rxd_in;
            cdsop_pkg::TSEL_SYNC: tpin_next = mux_sync_in;
            cdsop_pkg::TSEL_CK10: tpin_next = clock_10mhz_in;
            cdsop_pkg::TSEL_CKCPU: tpin_next = processor_clock_in;
            cdsop_pkg::TSEL_CLOCK_38KHZ: tpin_next = clock_38khz_in;
            default: tpin_next = 1'b0;
        endcase
    end

    // test pin register
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            tpin_reg <= 1'b0;
        end else begin
            tpin_reg <= tpin_next;
        end
    end
    assign test_output_pin_out = tpin_reg;
    assign analog_test_en_out = (tsel_reg <= cdsop_pkg::TSEL_ANA_LAST);
    assign analog_test_sel_out = tsel_reg[1:0];

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_rtm_sel;
        tsel_reg == cdsop_pkg::TSEL_RTM && !reg_wr_in;
    endsequence
    property p_test_output_select_rtm;
        @(posedge clk_sys_in) disable iff (rst_in)
            s_rtm_sel |=> test_output_pin_out == $past(mbit_reg);
    endproperty
    a_test_output_select_rtm: assert property (p_test_output_select_rtm) else $error("test pin not monitor");
    property p_rtm_low;
        @(posedge clk_sys_in) disable iff (rst_in)
            (mon_st_reg == cdsop_pkg::M_IDLE) |-> !mbit_reg || $past(mon_busy);
    endproperty
    a_rtm_low: assert property (p_rtm_low) else $error("monitor high while idle");
    property p_mon_off;
        @(posedge clk_sys_in) disable iff (rst_in)
            !mon_en_reg |=> !mon_busy && !mbit_reg;
    endproperty
    a_mon_off: assert property (p_mon_off) else $error("monitor runs disabled");
    sequence s_mon_go;
        mon_en_reg && sync_rise && !mon_busy;
    endsequence
    property p_mon_start;
        @(posedge clk_sys_in) disable iff (rst_in)
            s_mon_go ##1 mon_en_reg |-> mon_st_reg == cdsop_pkg::M_LOAD;
    endproperty
    a_mon_start: assert property (p_mon_start) else $error("monitor missed sync");
    property p_frame_width;
        @(posedge clk_sys_in) disable iff (rst_in)
            frame_reg && rise && ser_en |=> !frame_reg;
    endproperty
    a_frame_width: assert property (p_frame_width) else $error("frame too long");
    property p_rdy_hold;
        @(posedge clk_sys_in) disable iff (rst_in)
            ser_st_reg == cdsop_pkg::S_FIELD && !rdy_ok |=> !frame_reg;
    endproperty
    a_rdy_hold: assert property (p_rdy_hold) else $error("frame without ready");
    property p_ser_off;
        @(posedge clk_sys_in) disable iff (rst_in)
            !ser_en |=> !ser_busy && !sclk_reg;
    endproperty
    a_ser_off: assert property (p_ser_off) else $error("serial runs disabled");
    property p_gate_idle;
        @(posedge clk_sys_in) disable iff (rst_in)
            ser_gate && !ser_busy ##1 ser_gate && !ser_busy |-> !sclk_reg;
    endproperty
    a_gate_idle: assert property (p_gate_idle) else $error("gated clock runs idle");
    property p_frame_pol;
        @(posedge clk_sys_in) disable iff (rst_in)
            ser_en |-> seg5_pin_out == (frame_reg ^ ser_pol);
    endproperty
    a_frame_pol: assert property (p_frame_pol) else $error("frame polarity wrong");
endmodule

/* tb/cdsop_rx_model.sv */
// receiving logger model for the serial port pins
`timescale 1ns/100ps
module cdsop_rx_model (
    // serial pins from the device
    input wire logic sclk_in,
    input wire logic data_in,
    input wire logic frame_in,
    input wire logic pol_in,
    // handshake and received words
    output logic ready_out = 1'b1,
    output logic [31:0] word_out = 32'h0,
    output logic tog_out = 1'b0
);
    int cnt = 0; // bits left in the field
    logic [31:0] sh = 32'h0; // incoming bits
    // ready moves only on rising serial clock; stalls at random to delay fields
    always @(posedge sclk_in) begin
        ready_out <= ($urandom % 4) != 0;
    end
    // data is launched on the rising edge, so it is taken on the falling one
    always @(negedge sclk_in) begin
        if (cnt != 0) begin
            sh = {sh[30:0], data_in};
            cnt = cnt - 1;
            if (cnt == 0) begin
                word_out <= sh;
                tog_out <= ~tog_out;
            end
        end else if (frame_in ^ pol_in) begin
            cnt = 32;
        end
    end
endmodule

/* tb/ce_data_serial_output_ports_tb.sv */
// self-checking bench for the serial output block
`timescale 1ns/100ps
module ce_data_serial_output_ports_tb;
    logic clk_sys = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, sync = 1'b0, rxd = 1'b0;
    logic [15:0] addr = 16'h0, wdata = 16'h0, rdata, st;
    logic [8:0] mon_a, ser_a, a0;
    logic [31:0] mon_d = 32'h0, ser_d = 32'h0, key, rx_word;
    logic [3:0] lcd = 4'h0;
    logic tpin, aen, s3, s4, s5, s6o, s6oe, rdy, rx_tog, ldis, pol = 1'b0;
    logic [1:0] asel;
    logic [8:0] ma[4]; // monitor word addresses
    logic [31:0] mw; // monitor word as seen on the test pin
    int n;
    int fail_count = 0, checks_done = 0;
    logic [31:0] exp_q[$];
    cdsop_core u_dut (.clk_sys_in(clk_sys), .rst_in(rst), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
        .mux_sync_in(sync), .mon_ram_addr_out(mon_a), .mon_ram_data_in(mon_d),
        .ser_ram_addr_out(ser_a), .ser_ram_data_in(ser_d), .comparator2_in(1'b0),
        .comparator3_in(1'b0), .optical_rxd_in(rxd), .clock_10mhz_in(1'b0),
        .processor_clock_in(1'b0), .clock_38khz_in(1'b0), .test_output_pin_out(tpin),
        .analog_test_en_out(aen), .analog_test_sel_out(asel), .lcd_seg_in(lcd),
        .seg3_pin_out(s3), .seg4_pin_out(s4), .seg5_pin_out(s5),
        .seg6_pin_in(s6oe ? s6o : rdy), .seg6_pin_out(s6o), .seg6_pin_oe_out(s6oe),
        .lcd_disable_out(ldis));
    cdsop_rx_model u_rx (.sclk_in(s3), .data_in(s4), .frame_in(s5), .pol_in(pol),
        .ready_out(rdy), .word_out(rx_word), .tog_out(rx_tog));
    initial begin
        forever #50 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] word(input logic [8:0] a);
        return key ^ {a[7:0], ~a[7:0], a[7:0], 7'h0, a[8]};
    endfunction
    // ram answers one cycle after the address
    always @(posedge clk_sys) begin
        mon_d <= word(mon_a);
        ser_d <= word(ser_a);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk_sys);
        wr_s <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk_sys);
        rd_s <= 1'b0;
        #1 d = rdata;
        @(posedge clk_sys);
    endtask
    task automatic stop_test;
        $display("fail_count=%0d checks_done=%0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // every received field is matched against the oldest noted word
    always @(rx_tog) begin
        if (!rst) chk(rx_word, exp_q.size() ? exp_q.pop_front() : ~rx_word);
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        fail_count++;
        stop_test;
    end
    initial begin
        void'($urandom(17239));
        key = $urandom;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(cdsop_pkg::ADDR_TEST_SEL, st);
        chk(st, 32'(cdsop_pkg::TEST_SEL_RST));
        chk(aen, 32'h1);
        chk({ldis, s6oe, asel}, 32'h4);
        rd(cdsop_pkg::ADDR_SER_CTL, st);
        chk(st, 32'(cdsop_pkg::SER_CTL_RST));
        rd(16'h2010, st);
        chk(st, 32'h0);
        wr(cdsop_pkg::ADDR_TEST_SEL, 16'(cdsop_pkg::TSEL_RXD));
        repeat (8) begin
            rxd <= 1'($urandom);
            @(posedge clk_sys);
            @(posedge clk_sys);
            #1 chk(tpin, rxd);
        end
        // monitor: four words on the test pin, flag then msb first, 140 cycles apart
        for (int k = 0; k < 4; k++) begin
            ma[k] = 9'($urandom);
            wr(cdsop_pkg::ADDR_MON_A0 + 16'(k), 16'(ma[k]));
        end
        wr(cdsop_pkg::ADDR_TEST_SEL, 16'(cdsop_pkg::TSEL_RTM));
        wr(cdsop_pkg::ADDR_MON_CTL, 16'h0001);
        sync <= 1'b1;
        @(posedge clk_sys);
        sync <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            // find the first cycle of the flag bit
            for (n = 0; n < 200 && tpin !== 1'b1; n++) begin
                @(posedge clk_sys);
                #1;
            end
            if (k > 0) chk(n, 32'h6);
            // sample each data bit in the middle of its four cycles
            repeat (6) @(posedge clk_sys);
            for (int b = 0; b < 32; b++) begin
                #1 mw = {mw[30:0], tpin};
                repeat (4) @(posedge clk_sys);
            end
            #1 chk(mw, word(ma[k]));
            chk(tpin, 32'h0);
        end
        repeat (12) @(posedge clk_sys);
        #1 chk(tpin, 32'h0);
        @(posedge clk_sys);
        rd(cdsop_pkg::ADDR_STATUS, st);
        chk(st[0], 32'h0);
        // a sync while disabled must not start the monitor
        wr(cdsop_pkg::ADDR_MON_CTL, 16'h0000);
        sync <= 1'b1;
        @(posedge clk_sys);
        sync <= 1'b0;
        rd(cdsop_pkg::ADDR_STATUS, st);
        chk(st[0], 32'h0);
        // slow, fast, then free-running slow clock with ready ignored
        for (int i = 0; i < 3; i++) begin
            a0 = 9'($urandom % 500);
            pol <= i[0];
            wr(cdsop_pkg::ADDR_SER_START, 16'(a0));
            wr(cdsop_pkg::ADDR_SER_END, 16'(a0 + 9'h2));
            wr(cdsop_pkg::ADDR_SER_CTL, i == 2 ? 16'h31 : 16'h3d | 16'(i << 1) | 16'(i << 6));
            chk(ldis, 32'h1);
            for (int k = 0; k < 3; k++) exp_q.push_back(word(a0 + 9'(k)));
            sync <= 1'b1;
            repeat (3) @(posedge clk_sys);
            sync <= 1'b0;
            for (int n = 0; n < 400; n++) begin
                rd(cdsop_pkg::ADDR_STATUS, st);
                if (st[1] == 1'b0) break;
            end
            repeat (8) @(posedge clk_sys);
            chk(exp_q.size(), 32'h0);
        end
        stop_test;
    end
endmodule
